/* File: mcsp_pkg.sv */
// mcsp_pkg: constants for the processor core register bank
// assumes: included first; every user writes mcsp_pkg::name
package mcsp_pkg;
  // ****************************************
  // register offsets
  // ****************************************
  localparam logic [7:0] OFS_PORT_LINES_0_3 = 8'h80;
  localparam logic [7:0] OFS_STACK_POINTER = 8'h81;
  localparam logic [7:0] OFS_DATA_POINTER0_LOW = 8'h82;
  localparam logic [7:0] OFS_DATA_POINTER0_HIGH = 8'h83;
  localparam logic [7:0] OFS_DATA_POINTER1_LOW = 8'h84;
  localparam logic [7:0] OFS_DATA_POINTER1_HIGH = 8'h85;
  localparam logic [7:0] OFS_MEMORY_STRETCH_CONTROL = 8'h8e;
  localparam logic [7:0] OFS_PORT_LINES_4_7 = 8'h90;
  localparam logic [7:0] OFS_PORT_LINES_8_11 = 8'ha0;
  localparam logic [7:0] OFS_PORT_LINES_12_14 = 8'hb0;
  localparam logic [7:0] OFS_PROCESSOR_STATUS_WORD = 8'hd0;
  localparam logic [7:0] OFS_MULTIPLY_DIVIDE_OPERAND = 8'hf0;
  // ****************************************
  // reset values
  // ****************************************
  localparam logic [7:0] RST_PORT = 8'hff;
  localparam logic [7:0] RST_STACK_POINTER = 8'h07;
  localparam logic [7:0] RST_ZERO8 = 8'h00;
  localparam logic [15:0] RST_PROGRAM_COUNTER = 16'h0000;
  localparam logic [7:0] RST_MEMORY_STRETCH_CONTROL = 8'h01;
  // ****************************************
  // status word fields
  // ****************************************
  localparam int PSW_CARRY_FLAG = 7;
  localparam int PSW_NIBBLE_CARRY_FLAG = 6;
  localparam int PSW_USER_FLAG_FIVE = 5;
  localparam int PSW_BANK_SELECT_HIGH = 4;
  localparam int PSW_BANK_SELECT_LOW = 3;
  localparam int PSW_OVERFLOW_FLAG = 2;
  localparam int PSW_USER_FLAG_ONE = 1;
  localparam int PSW_PARITY = 0;
  localparam logic [7:0] BANK_SIZE = 8'h08;
  // ****************************************
  // port and stretch fields
  // ****************************************
  localparam int LINE_COUNT = 15;
  localparam logic [3:0] TOP_PORT_MASK = 4'h7;
  localparam logic [3:0] STRETCH_ONE = 4'h1;
  localparam logic [3:0] READ_EXTRA = 4'h0;
  localparam logic [3:0] WRITE_EXTRA = 4'h1;
endpackage

/* File: mcsp_core.sv */
// mcsp_core: core special-function registers, port lines and move stretch
// assumes: execution logic drives single-cycle pulses on mclk; a plain
// register port with read data one cycle after the read strobe
`timescale 1ns/1ns
module mcsp_core (
  // clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  // execution unit
  input wire logic [7:0] acc_value,
  input wire logic flag_update,
  input wire logic carry_in,
  input wire logic nibble_carry_in,
  input wire logic overflow_in,
  input wire logic operand_we,
  input wire logic [7:0] operand_wdata,
  input wire logic stack_push,
  input wire logic stack_pop,
  input wire logic pc_advance,
  input wire logic pc_load,
  input wire logic [15:0] pc_load_value,
  input wire logic data_pointer_sel,
  // core state out
  output logic [7:0] operand_value,
  output logic [7:0] status_value,
  output logic [7:0] stack_pointer_value,
  output logic [7:0] bank_base,
  output logic [15:0] program_counter,
  output logic [15:0] code_read_addr,
  // port lines
  input wire logic port_enable,
  input wire logic [14:0] line_in,
  output logic [14:0] line_out,
  output logic [14:0] line_oe,
  // external data move
  input wire logic xmove_req,
  input wire logic xmove_write,
  output logic xmove_busy,
  output logic [15:0] xmove_addr,
  output logic xmove_addr_valid,
  output logic xmove_rd_strobe,
  output logic xmove_wr_strobe
);

  // ****************************************
  // helpers
  // ****************************************
  function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    hit = (a == ofs);
  endfunction

  function automatic logic [7:0] port_read(input logic [7:0] latch,
                                           input logic [3:0] pins,
                                           input logic [3:0] dmask);
    port_read = {latch[7:4] & dmask, pins};
  endfunction

  // ****************************************
  // state
  // ****************************************
  logic [7:0] operand_reg, operand_next;
  logic [7:0] psw_reg, psw_next;
  logic [7:0] sp_reg, sp_next;
  logic [7:0] dp0l_reg, dp0l_next, dp0h_reg, dp0h_next;
  logic [7:0] dp1l_reg, dp1l_next, dp1h_reg, dp1h_next;
  logic [15:0] pc_reg, pc_next;
  logic [7:0] stretch_reg, stretch_next;
  logic [7:0] port0_reg, port0_next, port1_reg, port1_next;
  logic [7:0] port2_reg, port2_next, port3_reg, port3_next;
  logic [7:0] rdata_reg, rdata_next;
  logic [15:0] dp_sel;
  logic parity;

  // ****************************************
  // core registers
  // ****************************************
  // parity follows accumulator
  assign parity = ^acc_value;

  always_comb begin
    operand_next = operand_reg;
    psw_next = psw_reg;
    sp_next = sp_reg;
    dp0l_next = dp0l_reg;
    dp0h_next = dp0h_reg;
    dp1l_next = dp1l_reg;
    dp1h_next = dp1h_reg;
    pc_next = pc_reg;
    stretch_next = stretch_reg;
    if (reg_wr && hit(reg_addr, mcsp_pkg::OFS_MULTIPLY_DIVIDE_OPERAND)) begin
      operand_next = reg_wdata;
    end
    if (operand_we) begin
      operand_next = operand_wdata;
    end
    // software owns flags five, one and bank bits
    if (reg_wr && hit(reg_addr, mcsp_pkg::OFS_PROCESSOR_STATUS_WORD)) begin
      psw_next = reg_wdata;
    end
    // arithmetic update beats a software write
    if (flag_update) begin
      psw_next[mcsp_pkg::PSW_CARRY_FLAG] = carry_in;
      psw_next[mcsp_pkg::PSW_NIBBLE_CARRY_FLAG] = nibble_carry_in;
      psw_next[mcsp_pkg::PSW_OVERFLOW_FLAG] = overflow_in;
    end
    psw_next[mcsp_pkg::PSW_PARITY] = 1'b0;
    if (reg_wr && hit(reg_addr, mcsp_pkg::OFS_STACK_POINTER)) begin
      sp_next = reg_wdata;
    end
    if (stack_push) begin
      sp_next = sp_reg + 8'h01;
    end else if (stack_pop) begin
      sp_next = sp_reg - 8'h01;
    end
    if (reg_wr && hit(reg_addr, mcsp_pkg::OFS_DATA_POINTER0_LOW)) begin
      dp0l_next = reg_wdata;
    end
    if (reg_wr && hit(reg_addr, mcsp_pkg::OFS_DATA_POINTER0_HIGH)) begin
      dp0h_next = reg_wdata;
    end
    if (reg_wr && hit(reg_addr, mcsp_pkg::OFS_DATA_POINTER1_LOW)) begin
      dp1l_next = reg_wdata;
    end
    if (reg_wr && hit(reg_addr, mcsp_pkg::OFS_DATA_POINTER1_HIGH)) begin
      dp1h_next = reg_wdata;
    end
    if (pc_load) begin
      pc_next = pc_load_value;
    end else if (pc_advance) begin
      pc_next = pc_reg + 16'h0001;
    end
    if (reg_wr && hit(reg_addr, mcsp_pkg::OFS_MEMORY_STRETCH_CONTROL)) begin
      stretch_next = reg_wdata;
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      operand_reg <= mcsp_pkg::RST_ZERO8;
      psw_reg <= mcsp_pkg::RST_ZERO8;
      sp_reg <= mcsp_pkg::RST_STACK_POINTER;
      dp0l_reg <= mcsp_pkg::RST_ZERO8;
      dp0h_reg <= mcsp_pkg::RST_ZERO8;
      dp1l_reg <= mcsp_pkg::RST_ZERO8;
      dp1h_reg <= mcsp_pkg::RST_ZERO8;
      pc_reg <= mcsp_pkg::RST_PROGRAM_COUNTER;
      stretch_reg <= mcsp_pkg::RST_MEMORY_STRETCH_CONTROL;
    end else begin
      operand_reg <= operand_next;
      psw_reg <= psw_next;
      sp_reg <= sp_next;
      dp0l_reg <= dp0l_next;
      dp0h_reg <= dp0h_next;
      dp1l_reg <= dp1l_next;
      dp1h_reg <= dp1h_next;
      pc_reg <= pc_next;
      stretch_reg <= stretch_next;
    end
  end

  assign dp_sel = data_pointer_sel ? {dp1h_reg, dp1l_reg} : {dp0h_reg, dp0l_reg};
  assign code_read_addr = dp_sel;
  assign operand_value = operand_reg;
  assign status_value = {psw_reg[7:1], parity};
  assign stack_pointer_value = sp_reg;
  assign program_counter = pc_reg;
  // bank base is bank number times eight
  assign bank_base = {3'h0, psw_reg[mcsp_pkg::PSW_BANK_SELECT_HIGH],
                      psw_reg[mcsp_pkg::PSW_BANK_SELECT_LOW], 3'h0};

  // ****************************************
  // port lines
  // ****************************************
  always_comb begin
    port0_next = port0_reg;
    port1_next = port1_reg;
    port2_next = port2_reg;
    port3_next = port3_reg;
    // one register per group of lines
    // one write sets direction and level
    if (reg_wr && hit(reg_addr, mcsp_pkg::OFS_PORT_LINES_0_3)) begin
      port0_next = reg_wdata;
    end
    if (reg_wr && hit(reg_addr, mcsp_pkg::OFS_PORT_LINES_4_7)) begin
      port1_next = reg_wdata;
    end
    if (reg_wr && hit(reg_addr, mcsp_pkg::OFS_PORT_LINES_8_11)) begin
      port2_next = reg_wdata;
    end
    if (reg_wr && hit(reg_addr, mcsp_pkg::OFS_PORT_LINES_12_14)) begin
      port3_next = reg_wdata;
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      // outputs at reset, held off by enable
      port0_reg <= mcsp_pkg::RST_PORT;
      port1_reg <= mcsp_pkg::RST_PORT;
      port2_reg <= mcsp_pkg::RST_PORT;
      port3_reg <= mcsp_pkg::RST_PORT;
    end else begin
      port0_reg <= port0_next;
      port1_reg <= port1_next;
      port2_reg <= port2_next;
      port3_reg <= port3_next;
    end
  end

  assign line_out = {port3_reg[2:0], port2_reg[3:0], port1_reg[3:0], port0_reg[3:0]};
  // direction one drives; nothing driven until enabled
  assign line_oe = {port3_reg[6:4], port2_reg[7:4], port1_reg[7:4], port0_reg[7:4]}
                   & {mcsp_pkg::LINE_COUNT{port_enable}};

  // ****************************************
  // register read port
  // ****************************************
  always_comb begin
    rdata_next = 8'h00;
    if (reg_rd) begin
      case (reg_addr)
        mcsp_pkg::OFS_MULTIPLY_DIVIDE_OPERAND: rdata_next = operand_reg;
        mcsp_pkg::OFS_PROCESSOR_STATUS_WORD: rdata_next = {psw_reg[7:1], parity};
        mcsp_pkg::OFS_STACK_POINTER: rdata_next = sp_reg;
        mcsp_pkg::OFS_DATA_POINTER0_LOW: rdata_next = dp0l_reg;
        mcsp_pkg::OFS_DATA_POINTER0_HIGH: rdata_next = dp0h_reg;
        mcsp_pkg::OFS_DATA_POINTER1_LOW: rdata_next = dp1l_reg;
        mcsp_pkg::OFS_DATA_POINTER1_HIGH: rdata_next = dp1h_reg;
        mcsp_pkg::OFS_MEMORY_STRETCH_CONTROL: rdata_next = stretch_reg;
        // level bits come from the pins
        mcsp_pkg::OFS_PORT_LINES_0_3: rdata_next = port_read(port0_reg, line_in[3:0], 4'hf);
        mcsp_pkg::OFS_PORT_LINES_4_7: rdata_next = port_read(port1_reg, line_in[7:4], 4'hf);
        mcsp_pkg::OFS_PORT_LINES_8_11: rdata_next = port_read(port2_reg, line_in[11:8], 4'hf);
        // absent top direction bit reads zero
        mcsp_pkg::OFS_PORT_LINES_12_14: rdata_next = port_read(port3_reg,
                                          {1'b0, line_in[14:12]}, mcsp_pkg::TOP_PORT_MASK);
        default: rdata_next = 8'h00;
      endcase
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      rdata_reg <= 8'h00;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  assign reg_rdata = rdata_reg;

  // ****************************************
  // external data move sequencer
  // ****************************************
  // stretch sampled at start so a mid-move rewrite cannot bend the strobes
  typedef enum logic [2:0] {
    XM_IDLE = 3'b001,
    XM_READ = 3'b010,
    XM_WRITE = 3'b100
  } mcsp_xm_e;

  mcsp_xm_e xm_reg, xm_next;
  logic [3:0] cnt_reg, cnt_next;
  logic [3:0] len_reg, len_next;
  logic [15:0] xaddr_reg, xaddr_next;
  logic rd_reg, rd_next, wr_reg, wr_next;
  logic [3:0] st;
  logic [3:0] wr_len;

  assign st = {1'b0, stretch_reg[2:0]};
  // write strobe one cycle up to stretch one, else stretch
  assign wr_len = (len_reg <= mcsp_pkg::STRETCH_ONE) ? mcsp_pkg::STRETCH_ONE : len_reg;

  always_comb begin
    xm_next = xm_reg;
    cnt_next = cnt_reg;
    len_next = len_reg;
    xaddr_next = xaddr_reg;
    case (xm_reg)
      XM_IDLE: begin
        if (xmove_req) begin
          xm_next = xmove_write ? XM_WRITE : XM_READ;
          cnt_next = 4'h0;
          len_next = st;
          xaddr_next = dp_sel;
        end
      end
      XM_READ: begin
        // address and strobe stretch plus one
        if (cnt_reg == len_reg + mcsp_pkg::READ_EXTRA) begin
          xm_next = XM_IDLE;
        end else begin
          cnt_next = cnt_reg + 4'h1;
        end
      end
      XM_WRITE: begin
        if (cnt_reg == len_reg + mcsp_pkg::WRITE_EXTRA) begin
          xm_next = XM_IDLE;
        end else begin
          cnt_next = cnt_reg + 4'h1;
        end
      end
      default: begin
        xm_next = XM_IDLE;
      end
    endcase
  end

  function automatic logic [3:0] wr_len_n(input mcsp_xm_e s, input logic [3:0] stv,
                                          input logic [3:0] cur);
    if (s == XM_IDLE) begin
      wr_len_n = (stv <= mcsp_pkg::STRETCH_ONE) ? mcsp_pkg::STRETCH_ONE : stv;
    end else begin
      wr_len_n = cur;
    end
  endfunction

  always_comb begin
    rd_next = (xm_next == XM_READ);
    wr_next = 1'b0;
    // strobe after one cycle of address setup
    if (xm_next == XM_WRITE) begin
      wr_next = (cnt_next >= 4'h1) && (cnt_next <= wr_len_n(xm_reg, st, wr_len));
    end
  end

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      xm_reg <= XM_IDLE;
      cnt_reg <= 4'h0;
      len_reg <= 4'h0;
      xaddr_reg <= 16'h0000;
      rd_reg <= 1'b0;
      wr_reg <= 1'b0;
    end else begin
      xm_reg <= xm_next;
      cnt_reg <= cnt_next;
      len_reg <= len_next;
      xaddr_reg <= xaddr_next;
      rd_reg <= rd_next;
      wr_reg <= wr_next;
    end
  end

  assign xmove_busy = (xm_reg != XM_IDLE);
  assign xmove_addr_valid = (xm_reg != XM_IDLE);
  assign xmove_addr = xaddr_reg;
  assign xmove_rd_strobe = rd_reg;
  assign xmove_wr_strobe = wr_reg;

endmodule

/* File: mcsp_pin_model.sv */
// mcsp_pin_model: the board side of the fifteen port lines
// assumes: the bench picks, per line, whether an outside driver is present
`timescale 1ns/1ns
module mcsp_pin_model (
  // clock
  input wire logic mclk,
  input wire logic reset_n,
  // design side
  input wire logic [14:0] line_out,
  input wire logic [14:0] line_oe,
  // outside drivers
  input wire logic [14:0] ext_en,
  input wire logic [14:0] ext_val,
  // resolved pin levels
  output logic [14:0] line_in
);
  // ****************************************
  // pin resolution
  // ****************************************
  // a floating line churns so that a stale value is never read as valid
  logic [14:0] churn_reg;
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      churn_reg <= 15'h2aaa;
    end else begin
      churn_reg <= ~churn_reg;
    end
  end
  // driven lines show the design level
  assign line_in = (line_oe & line_out) | (~line_oe & ext_en & ext_val)
    | (~line_oe & ~ext_en & churn_reg);
endmodule

/* File: mcsp_core_chk.sv */
// mcsp_core_chk: timing checks on the core register bank ports
// assumes: bound onto mcsp_core, single clock mclk
`timescale 1ns/1ns
module mcsp_core_chk (
  // clock and reset
  input wire logic mclk,
  input wire logic reset_n,
  // observed ports
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic [7:0] acc_value,
  input wire logic stack_push,
  input wire logic pc_advance,
  input wire logic pc_load,
  input wire logic [7:0] status_value,
  input wire logic [7:0] stack_pointer_value,
  input wire logic [7:0] bank_base,
  input wire logic [15:0] program_counter,
  input wire logic port_enable,
  input wire logic [14:0] line_oe,
  input wire logic xmove_req,
  input wire logic xmove_write,
  input wire logic xmove_busy,
  input wire logic xmove_addr_valid,
  input wire logic xmove_rd_strobe,
  input wire logic xmove_wr_strobe
);
  // ****************************************
  // helper counters
  // ****************************************
  logic [2:0] str_reg, str_next, lat_reg, lat_next;
  logic [3:0] rd_cnt_reg, rd_cnt_next, wr_cnt_reg, wr_cnt_next, av_cnt_reg, av_cnt_next;
  logic wop_reg, wop_next;
  always_comb begin
    str_next = (reg_wr && reg_addr == 8'h8e) ? reg_wdata[2:0] : str_reg;
    lat_next = lat_reg;
    wop_next = wop_reg;
    if (xmove_req && !xmove_busy) begin
      lat_next = str_reg;
      wop_next = xmove_write;
    end
    rd_cnt_next = xmove_rd_strobe ? rd_cnt_reg + 4'h1 : 4'h0;
    wr_cnt_next = xmove_wr_strobe ? wr_cnt_reg + 4'h1 : 4'h0;
    av_cnt_next = xmove_addr_valid ? av_cnt_reg + 4'h1 : 4'h0;
  end
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      str_reg <= 3'h1;
      lat_reg <= 3'h0;
      wop_reg <= 1'b0;
      rd_cnt_reg <= 4'h0;
      wr_cnt_reg <= 4'h0;
      av_cnt_reg <= 4'h0;
    end else begin
      str_reg <= str_next;
      lat_reg <= lat_next;
      wop_reg <= wop_next;
      rd_cnt_reg <= rd_cnt_next;
      wr_cnt_reg <= wr_cnt_next;
      av_cnt_reg <= av_cnt_next;
    end
  end
  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);
  sequence s_take;
    xmove_req && !xmove_busy;
  endsequence
  chk_parity_live: assert property (status_value[0] == ^acc_value)
    else $error("parity bit does not follow accumulator");
  chk_bank_map: assert property (bank_base == {3'h0, status_value[4:3], 3'h0})
    else $error("bank base does not match bank select");
  chk_user_flags: assert property (!(reg_wr && reg_addr == 8'hd0) |=>
    $stable(status_value[5]) && $stable(status_value[1]))
    else $error("software flag changed without a write");
  chk_push_incr: assert property (stack_push |=>
    stack_pointer_value == $past(stack_pointer_value) + 8'h01)
    else $error("stack pointer not incremented on push");
  chk_pc_step: assert property (pc_advance && !pc_load |=>
    program_counter == $past(program_counter) + 16'h0001)
    else $error("program counter did not advance");
  chk_ports_float: assert property (!port_enable |-> line_oe == 15'h0000)
    else $error("line driven while ports disabled");
  chk_move_start: assert property (s_take |=> xmove_busy && xmove_addr_valid)
    else $error("move not started after request");
  chk_read_width: assert property ($fell(xmove_rd_strobe) |->
    rd_cnt_reg == {1'b0, lat_reg} + 4'h1)
    else $error("read strobe width wrong");
  chk_write_width: assert property ($fell(xmove_wr_strobe) |->
    wr_cnt_reg == ((lat_reg <= 3'h1) ? 4'h1 : {1'b0, lat_reg}))
    else $error("write strobe width wrong");
  chk_addr_width: assert property ($fell(xmove_addr_valid) |->
    av_cnt_reg == {1'b0, lat_reg} + (wop_reg ? 4'h2 : 4'h1))
    else $error("move address width wrong");
  chk_write_setup: assert property (s_take ##0 xmove_write |=>
    !xmove_wr_strobe ##1 xmove_wr_strobe)
    else $error("write strobe without setup cycle");
endmodule
bind mcsp_core mcsp_core_chk u_mcsp_core_chk (.*);

/* File: tb.sv */
// tb: register-port tests of the core register bank
// assumes: mcsp_core with the pin model on its port lines
`timescale 1ns/1ns
module tb;
  logic mclk, reset_n, reg_wr, reg_rd, flag_update, carry_in, nibble_carry_in, overflow_in;
  logic operand_we, stack_push, stack_pop, pc_advance, pc_load, data_pointer_sel, port_enable;
  logic xmove_req, xmove_write, xmove_busy, xmove_addr_valid, xmove_rd_strobe, xmove_wr_strobe;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, acc_value, operand_wdata, operand_value;
  logic [7:0] status_value, stack_pointer_value, bank_base;
  logic [15:0] pc_load_value, program_counter, code_read_addr, xmove_addr;
  logic [14:0] line_in, line_out, line_oe, ext_en, ext_val;
  int bad_count, n_tests;
  mcsp_core u_mcsp_core (.*);
  mcsp_pin_model u_mcsp_pin_model (.*);
  // ****************************************
  // tasks
  // ****************************************
  task automatic print_verdict();
    if (bad_count == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tick();
    @(posedge mclk);
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    tick();
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    tick();
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    tick();
    reg_rd <= 1'b1;
    reg_addr <= a;
    tick();
    reg_rd <= 1'b0;
    #1 chk({8'h00, reg_rdata}, {8'h00, exp});
  endtask
  // one external move; busy length counted against the stretch
  task automatic xmove(input logic w, input logic [2:0] s, input logic [15:0] a);
    int n;
    wr(8'h8e, {5'h00, s});
    xmove_req <= 1'b1;
    xmove_write <= w;
    tick();
    xmove_req <= 1'b0;
    n = 0;
    #1 chk(xmove_addr, a);
    while (xmove_busy === 1'b1 && n < 20) begin
      n++;
      // a second request while busy must be ignored
      xmove_req <= (n == 1);
      tick();
      #1;
    end
    xmove_req <= 1'b0;
    chk(16'(n), 16'(s) + (w ? 16'h0002 : 16'h0001));
  endtask
  // ****************************************
  // clock, watchdog, tests
  // ****************************************
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  initial begin
    #100_000;
    bad_count++;
    print_verdict();
  end
  initial begin
    {reg_wr, reg_rd, flag_update, carry_in, nibble_carry_in, overflow_in} = 6'h00;
    {operand_we, stack_push, stack_pop, pc_advance, pc_load, data_pointer_sel} = 6'h00;
    {port_enable, xmove_req, xmove_write, reset_n} = 4'h0;
    {reg_addr, reg_wdata, acc_value, operand_wdata, pc_load_value} = 48'h0000_0000_0000;
    ext_en = 15'h7fff;
    ext_val = 15'h5a3c;
    repeat (2) tick();
    reset_n <= 1'b1;
    rd(8'h81, 8'h07);
    rd(8'h8e, 8'h01);
    rd(8'hb0, 8'h75);
    rd(8'h80, 8'hfc);
    chk(program_counter, 16'h0000);
    chk({1'b0, line_oe}, 16'h0000);
    wr(8'h86, 8'hff);
    rd(8'h86, 8'h00);
    wr(8'hf0, 8'h5a);
    rd(8'hf0, 8'h5a);
    operand_we <= 1'b1;
    operand_wdata <= 8'ha5;
    tick();
    operand_we <= 1'b0;
    #1 chk({8'h00, operand_value}, 16'h00a5);
    acc_value <= 8'h07;
    for (int b = 0; b < 4; b++) begin
      wr(8'hd0, {3'h1, b[1:0], 3'h2});
      #1 chk({8'h00, bank_base}, {11'h000, b[1:0], 3'h0});
      rd(8'hd0, {3'h1, b[1:0], 3'h3});
    end
    {flag_update, carry_in, nibble_carry_in, overflow_in} <= 4'hd;
    acc_value <= 8'h03;
    tick();
    flag_update <= 1'b0;
    #1 chk({8'h00, status_value}, 16'h00be);
    wr(8'h82, 8'h11);
    wr(8'h83, 8'h22);
    wr(8'h84, 8'h33);
    wr(8'h85, 8'h44);
    rd(8'h83, 8'h22);
    #1 chk(code_read_addr, 16'h2211);
    data_pointer_sel <= 1'b1;
    tick();
    #1 chk(code_read_addr, 16'h4433);
    stack_push <= 1'b1;
    tick();
    stack_push <= 1'b0;
    #1 chk({8'h00, stack_pointer_value}, 16'h0008);
    pc_advance <= 1'b1;
    repeat (3) tick();
    pc_advance <= 1'b0;
    #1 chk(program_counter, 16'h0003);
    stack_pop <= 1'b1;
    tick();
    stack_pop <= 1'b0;
    #1 chk({8'h00, stack_pointer_value}, 16'h0007);
    pc_load_value <= 16'h1234;
    {pc_load, pc_advance} <= 2'h3;
    tick();
    {pc_load, pc_advance} <= 2'h0;
    #1 chk(program_counter, 16'h1234);
    // lines programmed before the global enable
    wr(8'h80, 8'h35);
    #1 chk({1'b0, line_oe}, 16'h0000);
    port_enable <= 1'b1;
    tick();
    #1 chk({1'b0, line_oe}, 16'h7ff3);
    chk({1'b0, line_out}, 16'h7ff5);
    rd(8'h80, 8'h3d);
    wr(8'hb0, 8'h0a);
    rd(8'hb0, 8'h05);
    wr(8'hb0, 8'hff);
    rd(8'hb0, 8'h77);
    for (int s = 0; s < 8; s++) begin
      xmove(1'b0, s[2:0], 16'h4433);
      xmove(1'b1, s[2:0], 16'h4433);
    end
    reset_n <= 1'b0;
    tick();
    reset_n <= 1'b1;
    rd(8'h81, 8'h07);
    rd(8'h8e, 8'h01);
    chk(program_counter, 16'h0000);
    print_verdict();
  end
endmodule
